// File: dv/program_status_flags_tb_top.sv
`default_nettype none
module program_status_flags_tb_top
	import psf_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	logic aclk = 1'b0;
	logic aresetn = 1'b0;
	logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
	logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
	logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
	logic [31:0] s_axi_wdata = 32'h0;
	logic [3:0] s_axi_wstrb = 4'h0;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, carry_out;
	logic [1:0] s_axi_bresp, s_axi_rresp, rs;
	logic [31:0] s_axi_rdata, rd, keep;
	logic [7:0] acc, status_word, reg_addr;
	logic [2:0] reg_num;
	psf_alu_t alu;
	psf_bitop_t bitop;
	int n_mismatch = 0;
	int checked = 0;
	psf_core_model core (.aclk(aclk), .acc(acc), .alu(alu), .bitop(bitop), .reg_num(reg_num));
	psf_status dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr),
		.s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
		.s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
		.s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
		.s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
		.s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
		.s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
		.s_axi_rready(s_axi_rready), .acc(acc), .alu(alu), .bitop(bitop), .reg_num(reg_num),
		.status_word(status_word), .carry_out(carry_out), .reg_addr(reg_addr));
	initial begin
		forever #50 aclk = ~aclk;
	end
	////////////////////////////////////////////////////////////////////////
	task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string m);
		checked++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("CHECK FAILED %0t %s seen %h expected %h", $time, m, seen, exp);
		end
	endtask
	task automatic give_verdict();
		$display("checks %0d mismatches %0d", checked, n_mismatch);
		if (n_mismatch == 0 && checked > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask
	task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_awvalid <= 1'b1;
		s_axi_wdata <= d;
		s_axi_wstrb <= s;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		// Beats may be taken at different edges
		do begin
			@(posedge aclk);
			if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
			#1;
		end while (s_axi_awvalid || s_axi_wvalid);
		do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
		rs = s_axi_bresp;
		s_axi_bready <= 1'b0;
	endtask
	task automatic axi_rd(input logic [7:0] a);
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do @(posedge aclk); while (s_axi_arready !== 1'b1);
		s_axi_arvalid <= 1'b0;
		do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
		rd = s_axi_rdata;
		rs = s_axi_rresp;
		s_axi_rready <= 1'b0;
	endtask
	////////////////////////////////////////////////////////////////////////
	task automatic t_reset();
		axi_rd(PSF_STATUS_OFS);
		check(rd, {24'h0, PSF_STATUS_RST}, "reset value");
		check(status_word, 8'h00, "reset flags");
		$display("test reset done");
	endtask
	task automatic t_alu();
		for (int i = 0; i < 8; i++) begin
			core.alu_op(i[2], i[1], i[0]);
			@(negedge aclk);
			check(status_word[7:6], {i[2], i[1]}, "carry pair");
			check(status_word[2], i[2] ^ i[0], "overflow");
			check(carry_out, i[2], "carry out");
		end
		$display("test alu done");
	endtask
	task automatic t_bitop();
		psf_bop_t ops[7] = '{PSF_BOP_SET, PSF_BOP_AND, PSF_BOP_AND, PSF_BOP_OR, PSF_BOP_INV,
			PSF_BOP_COPY, PSF_BOP_CLR};
		// Second AND clears through an inverted source
		logic [6:0] b = 7'b0100111;
		logic [6:0] inv = 7'b0001100;
		logic [6:0] exp = 7'b0101011;
		for (int i = 0; i < 7; i++) begin
			core.bit_op(ops[i], b[i], inv[i]);
			@(negedge aclk);
			check(carry_out, exp[i], "bit op");
		end
		$display("test bitop done");
	endtask
	task automatic t_bank();
		logic [7:0] w;
		for (int k = 0; k < 4; k++) begin
			core.set_acc(8'h00, 3'(k + 3));
			w = {2'b00, k[0], k[1:0], 1'b0, ~k[0], 1'b1};
			axi_wr(PSF_STATUS_OFS, {24'h0, w}, 4'h1);
			axi_rd(PSF_STATUS_OFS);
			check(rd, {24'h0, w[7:1], 1'b0}, "user flags and bank");
			check(reg_addr, {3'b000, k[1:0], 3'(k + 3)}, "bank address");
		end
		$display("test bank done");
	endtask
	task automatic t_parity();
		logic [7:0] v[6] = '{8'h01, 8'h03, 8'h80, 8'hff, 8'h7f, 8'h00};
		foreach (v[i]) begin
			core.set_acc(v[i], 3'h0);
			@(negedge aclk);
			check(status_word[0], ^v[i], "parity");
		end
		$display("test parity done");
	endtask
	// Refused places must leave the word untouched
	task automatic t_refuse();
		axi_rd(PSF_STATUS_OFS);
		keep = rd;
		axi_wr(8'hd4, 32'hff, 4'h1);
		check(rs, PSF_RESP_SLVERR, "bad write resp");
		axi_rd(8'hd4);
		check({rd, rs}, {32'h0, PSF_RESP_SLVERR}, "bad read");
		axi_wr(PSF_STATUS_OFS, 32'hff, 4'h0);
		check(rs, PSF_RESP_OKAY, "no strobe resp");
		axi_rd(PSF_STATUS_OFS);
		check(rd, keep, "no strobe write");
		$display("test refuse done");
	endtask
	////////////////////////////////////////////////////////////////////////
	initial begin
		repeat (4) @(posedge aclk);
		aresetn <= 1'b1;
		t_reset();
		t_alu();
		t_bitop();
		t_bank();
		t_parity();
		t_refuse();
		give_verdict();
	end
	initial begin
		repeat (PSF_TIMEOUT_CYC) @(posedge aclk);
		n_mismatch++;
		give_verdict();
	end
endmodule
`default_nettype wire

// File: dv/psf_core_model.sv
`default_nettype none
module psf_core_model
	import psf_pkg::*;
(
	// Clock
	input wire logic aclk,
	// Execution logic outputs
	output logic [7:0] acc,
	output var psf_alu_t alu,
	output var psf_bitop_t bitop,
	output logic [2:0] reg_num
);
	timeunit 1ns;
	timeprecision 1ns;
	initial begin
		acc = 8'h00;
		alu = '0;
		bitop = '{PSF_BOP_NONE, 1'b0, 1'b0};
		reg_num = 3'h0;
	end
	task automatic set_acc(input logic [7:0] a, input logic [2:0] r);
		@(posedge aclk);
		acc <= a;
		reg_num <= r;
	endtask
	// Requests last one cycle, as the execution logic issues them
	task automatic alu_op(input logic c, input logic n, input logic b6);
		@(posedge aclk);
		alu <= '{1'b1, c, n, b6};
		@(posedge aclk);
		alu <= '0;
	endtask
	task automatic bit_op(input psf_bop_t op, input logic b, input logic inv);
		@(posedge aclk);
		bitop <= '{op, b, inv};
		@(posedge aclk);
		bitop <= '{PSF_BOP_NONE, 1'b0, 1'b0};
	endtask
endmodule
`default_nettype wire

// File: hw/psf_bank_map.sv
`default_nettype none
module psf_bank_map
	import psf_pkg::*;
(
	// Bank select and register number
	input wire logic [1:0] bank_sel,
	input wire logic [2:0] reg_num,
	// Scratch-pad address
	output logic [7:0] ram_addr
);
	always_comb begin
		ram_addr = {3'h0, bank_sel, reg_num};
	end
endmodule
`default_nettype wire

// File: hw/psf_status.sv
// Overview of operation
// - Bit 7 carry flag is set when an ALU operation carries out, cleared otherwise.
// - The carry flag is source and destination of Boolean bit instructions.
// - Bit 6 nibble carry flag records a carry across the nibble boundary.
// - Bit 5 user flag zero is plain software storage with no hardware effect.
// - Bit 2 overflow flag is the exclusive-or of carries out of bit six and bit seven.
// - Bit 1 user flag one is plain software storage.
// - Bit 0 parity flag is one when the accumulator has an odd count of ones.
// - Bits 4..3 select the working bank at RAM 00-07h, 08-0Fh, 10-17h or 18-1Fh.
`default_nettype none
module psf_status
	import psf_pkg::*;
(
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// AXI4-Lite write address and data
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	// AXI4-Lite write response
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	// AXI4-Lite read
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// Execution logic side
	input wire logic [7:0] acc,
	input wire psf_alu_t alu,
	input wire psf_bitop_t bitop,
	input wire logic [2:0] reg_num,
	output logic [7:0] status_word,
	output logic carry_out,
	output logic [7:0] reg_addr
);
	////////////////////////////////////////////////////////////////////////
	function automatic logic odd_parity(input logic [7:0] v);
		return ^v;
	endfunction

	// Any byte of the status word's aligned word hits it
	function automatic logic addr_hit(input logic [7:0] a);
		return a[7:2] == PSF_STATUS_OFS[7:2];
	endfunction

	function automatic logic bit_op(input psf_bitop_t b, input logic carry);
		logic src;
		src = b.bit_inv ? ~b.bit_in : b.bit_in;
		case (b.op)
			PSF_BOP_CLR: bit_op = 1'b0;
			PSF_BOP_SET: bit_op = 1'b1;
			PSF_BOP_INV: bit_op = ~carry;
			PSF_BOP_AND: bit_op = carry & src;
			PSF_BOP_OR: bit_op = carry | src;
			PSF_BOP_COPY: bit_op = src;
			default: bit_op = carry;
		endcase
	endfunction

	////////////////////////////////////////////////////////////////////////
	// Write channel: address and data latched independently
	logic aw_have_q, aw_have_d;
	logic w_have_q, w_have_d;
	logic [7:0] aw_addr_q, aw_addr_d;
	logic [7:0] w_data_q, w_data_d;
	logic w_strb_q, w_strb_d;
	logic bvalid_q, bvalid_d;
	logic [1:0] bresp_q, bresp_d;
	logic wr_fire;
	logic wr_hit;

	always_comb begin
		aw_have_d = aw_have_q;
		w_have_d = w_have_q;
		aw_addr_d = aw_addr_q;
		w_data_d = w_data_q;
		w_strb_d = w_strb_q;
		bvalid_d = bvalid_q;
		bresp_d = bresp_q;
		if (s_axi_awvalid && s_axi_awready) begin
			aw_have_d = 1'b1;
			aw_addr_d = s_axi_awaddr;
		end
		if (s_axi_wvalid && s_axi_wready) begin
			w_have_d = 1'b1;
			w_data_d = s_axi_wdata[7:0];
			w_strb_d = s_axi_wstrb[0];
		end
		if (wr_fire) begin
			aw_have_d = 1'b0;
			w_have_d = 1'b0;
			bvalid_d = 1'b1;
			bresp_d = wr_hit ? PSF_RESP_OKAY : PSF_RESP_SLVERR;
		end else if (bvalid_q && s_axi_bready) begin
			bvalid_d = 1'b0;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_have_q <= 1'b0;
			w_have_q <= 1'b0;
			aw_addr_q <= 8'h00;
			w_data_q <= 8'h00;
			w_strb_q <= 1'b0;
			bvalid_q <= 1'b0;
			bresp_q <= PSF_RESP_OKAY;
		end else begin
			aw_have_q <= aw_have_d;
			w_have_q <= w_have_d;
			aw_addr_q <= aw_addr_d;
			w_data_q <= w_data_d;
			w_strb_q <= w_strb_d;
			bvalid_q <= bvalid_d;
			bresp_q <= bresp_d;
		end
	end

	// Hold off new beats until the response drains
	assign s_axi_awready = !aw_have_q && !bvalid_q;
	assign s_axi_wready = !w_have_q && !bvalid_q;
	assign wr_fire = aw_have_q && w_have_q && !bvalid_q;
	assign wr_hit = addr_hit(aw_addr_q);
	assign s_axi_bvalid = bvalid_q;
	assign s_axi_bresp = bresp_q;

	////////////////////////////////////////////////////////////////////////
	// Read channel
	psf_rd_state_t rd_state_q, rd_state_d;
	logic [31:0] rdata_q, rdata_d;
	logic [1:0] rresp_q, rresp_d;

	always_comb begin
		rd_state_d = rd_state_q;
		rdata_d = rdata_q;
		rresp_d = rresp_q;
		case (rd_state_q)
			PSF_RD_IDLE: begin
				if (s_axi_arvalid) begin
					rd_state_d = PSF_RD_RESP;
					if (addr_hit(s_axi_araddr)) begin
						rdata_d = {24'h000000, status_word};
						rresp_d = PSF_RESP_OKAY;
					end else begin
						rdata_d = 32'h00000000;
						rresp_d = PSF_RESP_SLVERR;
					end
				end
			end
			PSF_RD_RESP: begin
				if (s_axi_rready) begin
					rd_state_d = PSF_RD_IDLE;
				end
			end
			default: rd_state_d = PSF_RD_IDLE;
		endcase
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rd_state_q <= PSF_RD_IDLE;
			rdata_q <= 32'h00000000;
			rresp_q <= PSF_RESP_OKAY;
		end else begin
			rd_state_q <= rd_state_d;
			rdata_q <= rdata_d;
			rresp_q <= rresp_d;
		end
	end

	assign s_axi_arready = (rd_state_q == PSF_RD_IDLE);
	assign s_axi_rvalid = (rd_state_q == PSF_RD_RESP);
	assign s_axi_rdata = rdata_q;
	assign s_axi_rresp = rresp_q;

	////////////////////////////////////////////////////////////////////////
	// Status word; core updates win over a software write in the same cycle
	logic carry_q, carry_d, nib_q, nib_d, ovf_q, ovf_d, usr0_q, usr0_d, usr1_q, usr1_d;
	logic [1:0] bank_q, bank_d;
	logic sw_wr;

	assign sw_wr = wr_fire && wr_hit && w_strb_q;

	always_comb begin
		carry_d = carry_q;
		nib_d = nib_q;
		ovf_d = ovf_q;
		usr0_d = usr0_q;
		usr1_d = usr1_q;
		bank_d = bank_q;
		if (sw_wr) begin
			carry_d = w_data_q[PSF_CARRY_POS];
			nib_d = w_data_q[PSF_NIBBLE_POS];
			usr0_d = w_data_q[PSF_USER0_POS];
			bank_d = w_data_q[PSF_BSH_POS:PSF_BSL_POS];
			ovf_d = w_data_q[PSF_OVFL_POS];
			usr1_d = w_data_q[PSF_USER1_POS];
		end
		if (alu.valid) begin
			carry_d = alu.carry;
			nib_d = alu.nibble_carry;
			ovf_d = alu.carry ^ alu.carry_b6;
		end else if (bitop.op != PSF_BOP_NONE) begin
			carry_d = bit_op(bitop, carry_q);
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			carry_q <= PSF_STATUS_RST[PSF_CARRY_POS];
			nib_q <= PSF_STATUS_RST[PSF_NIBBLE_POS];
			ovf_q <= PSF_STATUS_RST[PSF_OVFL_POS];
			usr0_q <= PSF_STATUS_RST[PSF_USER0_POS];
			usr1_q <= PSF_STATUS_RST[PSF_USER1_POS];
			bank_q <= PSF_STATUS_RST[PSF_BSH_POS:PSF_BSL_POS];
		end else begin
			carry_q <= carry_d;
			nib_q <= nib_d;
			ovf_q <= ovf_d;
			usr0_q <= usr0_d;
			usr1_q <= usr1_d;
			bank_q <= bank_d;
		end
	end

	// Parity is never stored, so a written value cannot survive
	always_comb begin
		status_word = {carry_q, nib_q, usr0_q, bank_q, ovf_q, usr1_q,
			odd_parity(acc)};
	end
	assign carry_out = carry_q;

	psf_bank_map u_bank_map (
		.bank_sel(bank_q),
		.reg_num(reg_num),
		.ram_addr(reg_addr)
	);

	////////////////////////////////////////////////////////////////////////
	carry_tracks_a: assert property (@(posedge aclk) disable iff (!aresetn)
		alu.valid |=> carry_out == $past(alu.carry))
		else $error("carry flag missed the ALU carry");
	bool_and_a: assert property (@(posedge aclk) disable iff (!aresetn)
		(!alu.valid && bitop.op == PSF_BOP_AND)
		|=> carry_out == ($past(carry_out) & ($past(bitop.bit_in) ^ $past(bitop.bit_inv))))
		else $error("Boolean AND on carry wrong");
	nibble_carry_a: assert property (@(posedge aclk) disable iff (!aresetn)
		alu.valid |=> status_word[PSF_NIBBLE_POS] == $past(alu.nibble_carry))
		else $error("nibble carry flag wrong");
	user_zero_a: assert property (@(posedge aclk) disable iff (!aresetn)
		!sw_wr |=> $stable(status_word[PSF_USER0_POS]))
		else $error("user flag zero changed without a write");
	overflow_xor_a: assert property (@(posedge aclk) disable iff (!aresetn)
		alu.valid |=> status_word[PSF_OVFL_POS] == ($past(alu.carry) ^ $past(alu.carry_b6)))
		else $error("overflow flag wrong");
	user_one_a: assert property (@(posedge aclk) disable iff (!aresetn)
		sw_wr |=> status_word[PSF_USER1_POS] == $past(w_data_q[PSF_USER1_POS]))
		else $error("user flag one not written");
	parity_odd_a: assert property (@(posedge aclk) disable iff (!aresetn)
		status_word[PSF_PARITY_POS] == (($countones(acc) % 2) == 1))
		else $error("parity flag wrong");
	bank_addr_a: assert property (@(posedge aclk) disable iff (!aresetn)
		reg_addr[7:PSF_BANK_SHIFT] == {3'h0, status_word[PSF_BSH_POS:PSF_BSL_POS]})
		else $error("bank mapping wrong");
	parity_sticky_a: assert property (@(posedge aclk) disable iff (!aresetn)
		(sw_wr && w_data_q[PSF_PARITY_POS] != ^acc) ##1 $stable(acc)
		|-> status_word[PSF_PARITY_POS] != $past(w_data_q[PSF_PARITY_POS]))
		else $error("parity kept a written value");
endmodule
`default_nettype wire

// File: inc/psf_pkg.sv
`default_nettype none
package psf_pkg;
	// Register map (byte address on the AXI4-Lite bus)
	localparam logic [7:0] PSF_STATUS_OFS = 8'hd0;
	localparam logic [7:0] PSF_STATUS_RST = 8'h00;
	// Bit positions within the status word
	localparam int PSF_CARRY_POS = 7;
	localparam int PSF_NIBBLE_POS = 6;
	localparam int PSF_USER0_POS = 5;
	localparam int PSF_BSH_POS = 4;
	localparam int PSF_BSL_POS = 3;
	localparam int PSF_OVFL_POS = 2;
	localparam int PSF_USER1_POS = 1;
	localparam int PSF_PARITY_POS = 0;
	// Bench watchdog span, far beyond the hundred or so cycles the tests take
	localparam int PSF_TIMEOUT_CYC = 3000;
	// Each bank spans eight bytes of low scratch-pad RAM
	localparam int PSF_BANK_SHIFT = 3;
	localparam logic [1:0] PSF_RESP_OKAY = 2'h0;
	localparam logic [1:0] PSF_RESP_SLVERR = 2'h2;

	// ALU result as offered by the execution logic
	typedef struct packed {
		logic valid;
		logic carry;
		logic nibble_carry;
		logic carry_b6;
	} psf_alu_t;

	// Boolean bit-manipulation request on the carry flag
	typedef enum logic [2:0] {
		PSF_BOP_NONE,
		PSF_BOP_CLR,
		PSF_BOP_SET,
		PSF_BOP_INV,
		PSF_BOP_AND,
		PSF_BOP_OR,
		PSF_BOP_COPY
	} psf_bop_t;

	typedef struct packed {
		psf_bop_t op;
		logic bit_in;
		logic bit_inv;
	} psf_bitop_t;

	typedef enum logic [1:0] {
		PSF_RD_IDLE,
		PSF_RD_RESP
	} psf_rd_state_t;
endpackage
`default_nettype wire
